// ### ufdp_pkg.sv
package ufdp_pkg;

    // Word indices of the registers on the AXI4-Lite bus.
    // Offsets not all multiples of four, so these are indices; byte address is four times.
    localparam logic [7:0] BUS_FAULT_FLAGS_IDX     = 8'hDA;
    localparam logic [7:0] DRIVE_PIO_HIGH_BYTE_IDX = 8'hDB;
    localparam logic [7:0] DRIVE_PIO_LOW_BYTE_IDX  = 8'hDC;
    localparam logic [7:0] XFER_COUNT_BYTE0_IDX    = 8'hE1;
    localparam logic [7:0] XFER_COUNT_BYTE1_IDX    = 8'hE2;
    localparam logic [7:0] XFER_COUNT_BYTE2_IDX    = 8'hE3;
    localparam logic [7:0] XFER_COUNT_BYTE3_IDX    = 8'hE4;
    localparam logic [7:0] DRIVE_STATUS_IDX        = 8'hE8;

    // Fault flag positions.
    localparam int FLT_TOKEN_BIT  = 6;
    localparam int FLT_STALL_BIT  = 4;
    localparam int FLT_TOGGLE_BIT = 3;
    localparam int FLT_RX_BIT     = 2;
    localparam int FLT_CRC_BIT    = 0;
    localparam logic [7:0] FLT_IMPL_MASK = 8'h5D;

    // Status register bit positions.
    localparam int STAT_DONE_BIT  = 0;
    localparam int STAT_FAULT_BIT = 1;

    // Reset values.
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

    // Bus response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### ufdp_reg_if.sv
// Register write/read strobes shared by the bus slave and the register bank.
interface ufdp_reg_if;
    logic        wr_en;
    logic [7:0]  wr_idx;
    logic [7:0]  wr_data;
    logic [7:0]  rd_idx;
    logic [7:0]  rd_data;
    logic        rd_hit;
    logic        wr_hit;

    modport slave (
        output wr_en,
        output wr_idx,
        output wr_data,
        output rd_idx,
        input  rd_data,
        input  rd_hit,
        input  wr_hit
    );

    modport bank (
        input  wr_en,
        input  wr_idx,
        input  wr_data,
        input  rd_idx,
        output rd_data,
        output rd_hit,
        output wr_hit
    );
endinterface

// ### ufdp_axil_slave.sv
// AXI4-Lite slave: takes address and data in either order; reads answer one cycle later, writes two.
module ufdp_axil_slave (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    ufdp_reg_if.slave        regs
);
    logic       aw_held_q, aw_held_d;
    logic [7:0] aw_idx_q, aw_idx_d;
    logic       w_held_q, w_held_d;
    logic [7:0] w_data_q, w_data_d;
    logic       w_lane_q, w_lane_d;
    logic       bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic       rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic       do_wr;

    // Channel readies while nothing is pending.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign regs.wr_idx  = aw_idx_q;
    assign regs.wr_data = w_data_q;
    assign regs.rd_idx  = s_axi_araddr[9:2];
    assign do_wr        = aw_held_q && w_held_q && !bvalid_q;
    assign regs.wr_en   = do_wr && w_lane_q;

    // Next state of both channels.
    always_comb begin
        aw_held_d = aw_held_q;
        aw_idx_d  = aw_idx_q;
        w_held_d  = w_held_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            aw_idx_d  = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (do_wr) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = regs.wr_hit ? ufdp_pkg::RESP_OKAY : ufdp_pkg::RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rdata_d  = {24'h000000, regs.rd_data};
            rresp_d  = regs.rd_hit ? ufdp_pkg::RESP_OKAY : ufdp_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Channel state registers.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_idx_q  <= 8'h00;
            w_held_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= 2'h0;
        end else begin
            aw_held_q <= aw_held_d;
            aw_idx_q  <= aw_idx_d;
            w_held_q  <= w_held_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end
endmodule

// ### ufdp_count.sv
// Transfer byte counter: loaded by software, decremented by the transfer engine.
module ufdp_count #(
    parameter int WIDTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [1:0]       wr_lane,
    input  wire logic             wr_en,
    input  wire logic [7:0]       wr_data,
    input  wire logic             dec,
    output logic      [WIDTH-1:0] count,
    output logic                  start
);
    logic [WIDTH-1:0] count_q, count_d;
    logic             start_q, start_d;

    assign count = count_q;
    assign start = start_q;

    // Byte writes patch the count; a write to lane zero also starts a transfer.
    always_comb begin
        count_d = count_q;
        start_d = 1'b0;
        if (dec && count_q != '0) begin
            count_d = count_q - WIDTH'(1);
        end
        if (wr_en) begin
            count_d[wr_lane*8 +: 8] = wr_data;
            start_d = (wr_lane == 2'h0);
        end
    end

    // Count registers.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= ufdp_pkg::COUNT_RESET;
            start_q <= 1'b0;
        end else begin
            count_q <= count_d;
            start_q <= start_d;
        end
    end
endmodule

// ### ufdp_regs.sv
// How it works
// RULE1 - Unexpected token on any endpoint sets fault flag bit 6.
// RULE2 - Token to a stalled endpoint sets fault flag bit 4.
// RULE3 - Received data with wrong toggle sets fault flag bit 3.
// RULE4 - Full-speed receive error sets fault flag bit 2.
// RULE5 - CRC failure sets fault flag bit 0.
// RULE6 - Fault bits 7, 5 and 1 read zero and ignore writes.
// RULE7 - Writing one clears a fault flag; zero leaves it.
// RULE8 - Status fault summary bit is high while any fault flag is set.
// RULE9 - High holding byte is driven as upper half of 16-bit drive writes.
// RULE10 - 16-bit drive read puts upper byte in high holding register at done.
// RULE11 - Software discards the direct load value and reads holding registers.
// RULE12 - 8-bit drive register reads put their byte in low holding register.
// RULE13 - 16-bit drive read puts lower byte in low holding register at done.
// RULE14 - Low holding register is unused and untouched by drive writes.
// RULE15 - Count bytes 0..2 read and write at 0xE1, 0xE2, 0xE3.
// RULE16 - Count byte 3 reads and writes at 0xE4.
// RULE17 - Writing count byte 0 last starts a new transfer.
// RULE18 - Count reads return bytes still remaining.
// RULE19 - Access done sets at access end, clears on write one or next access start.
// RULE20 - All registers reset to zero; flags stay set until cleared.
module ufdp_regs (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AXI4-Lite register port.
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // One-cycle fault events from the packet receiver.
    input  wire logic        ev_token_fault,
    input  wire logic        ev_stall_fault,
    input  wire logic        ev_data_toggle_fault,
    input  wire logic        ev_receive_fault,
    input  wire logic        ev_crc_fault,
    output logic             fault_summary,
    // Programmed drive access from the access sequencer.
    input  wire logic        drive_access_start,
    input  wire logic        drive_access_end,
    input  wire logic        drive_access_read,
    input  wire logic        drive_access_wide,
    input  wire logic [15:0] drive_read_data,
    output logic [7:0]       drive_write_high,
    output logic             drive_access_done,
    // Transfer engine hooks.
    input  wire logic        xfer_byte_done,
    output logic [31:0]      xfer_remaining,
    output logic             xfer_start
);
    ufdp_reg_if regs ();

    logic [7:0]  flags_q, flags_d;
    logic [7:0]  high_q, high_d;
    logic [7:0]  low_q, low_d;
    logic        done_q, done_d;
    logic [7:0]  events;
    logic        wr_flags, wr_high, wr_low, wr_stat, wr_cnt;
    logic [1:0]  cnt_lane;
    logic [31:0] count;

    // Index match for the write side; the read side decodes with a case.
    function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
        return idx == reg_idx;
    endfunction

    ufdp_axil_slave u_slave (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs)
    );

    // Write decode.
    assign wr_flags = regs.wr_en && hit(regs.wr_idx, ufdp_pkg::BUS_FAULT_FLAGS_IDX);
    assign wr_high  = regs.wr_en && hit(regs.wr_idx, ufdp_pkg::DRIVE_PIO_HIGH_BYTE_IDX);
    assign wr_low   = regs.wr_en && hit(regs.wr_idx, ufdp_pkg::DRIVE_PIO_LOW_BYTE_IDX);
    assign wr_stat  = regs.wr_en && hit(regs.wr_idx, ufdp_pkg::DRIVE_STATUS_IDX);
    assign wr_cnt   = regs.wr_en && regs.wr_idx >= ufdp_pkg::XFER_COUNT_BYTE0_IDX
                      && regs.wr_idx <= ufdp_pkg::XFER_COUNT_BYTE3_IDX;
    assign cnt_lane = 2'(regs.wr_idx - ufdp_pkg::XFER_COUNT_BYTE0_IDX);
    assign regs.wr_hit = hit(regs.wr_idx, ufdp_pkg::BUS_FAULT_FLAGS_IDX)
                      || hit(regs.wr_idx, ufdp_pkg::DRIVE_PIO_HIGH_BYTE_IDX)
                      || hit(regs.wr_idx, ufdp_pkg::DRIVE_PIO_LOW_BYTE_IDX)
                      || hit(regs.wr_idx, ufdp_pkg::DRIVE_STATUS_IDX)
                      || (regs.wr_idx >= ufdp_pkg::XFER_COUNT_BYTE0_IDX
                          && regs.wr_idx <= ufdp_pkg::XFER_COUNT_BYTE3_IDX);

    // Transfer counter.
    // RULE15 RULE16 RULE17 byte-wide count
    ufdp_count #(
        .WIDTH (32)
    ) u_count (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_lane (cnt_lane),
        .wr_en   (wr_cnt),
        .wr_data (regs.wr_data),
        .dec     (xfer_byte_done),
        .count   (count),
        .start   (xfer_start)
    );

    // Gather fault events into their flag positions.
    always_comb begin
        events = 8'h00;
        // RULE1 token fault
        events[ufdp_pkg::FLT_TOKEN_BIT] = ev_token_fault;
        // RULE2 stall fault
        events[ufdp_pkg::FLT_STALL_BIT] = ev_stall_fault;
        // RULE3 toggle fault
        events[ufdp_pkg::FLT_TOGGLE_BIT] = ev_data_toggle_fault;
        // RULE4 receive fault
        events[ufdp_pkg::FLT_RX_BIT] = ev_receive_fault;
        // RULE5 crc fault
        events[ufdp_pkg::FLT_CRC_BIT] = ev_crc_fault;
    end

    // Flags, holding bytes and access-done next values.
    always_comb begin
        flags_d = flags_q;
        high_d  = high_q;
        low_d   = low_q;
        done_d  = done_q;
        // RULE7 write one clears
        if (wr_flags) begin
            flags_d = flags_d & ~regs.wr_data;
        end
        // RULE6 RULE20 set wins, unused bits zero
        flags_d = (flags_d | events) & ufdp_pkg::FLT_IMPL_MASK;
        if (wr_high) begin
            high_d = regs.wr_data;
        end
        if (wr_low) begin
            low_d = regs.wr_data;
        end
        // RULE19 done clear paths
        if ((wr_stat && regs.wr_data[ufdp_pkg::STAT_DONE_BIT]) || drive_access_start) begin
            done_d = 1'b0;
        end
        // RULE10 RULE12 RULE13 RULE14 capture on read completion only
        if (drive_access_end) begin
            done_d = 1'b1;
            if (drive_access_read) begin
                low_d = drive_read_data[7:0];
                if (drive_access_wide) begin
                    high_d = drive_read_data[15:8];
                end
            end
        end
    end

    // Register bank state.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_q <= ufdp_pkg::BYTE_RESET;
            high_q  <= ufdp_pkg::BYTE_RESET;
            low_q   <= ufdp_pkg::BYTE_RESET;
            done_q  <= 1'b0;
        end else begin
            flags_q <= flags_d;
            high_q  <= high_d;
            low_q   <= low_d;
            done_q  <= done_d;
        end
    end

    // RULE8 fault summary
    assign fault_summary     = |flags_q;
    // RULE9 high byte drive
    assign drive_write_high  = high_q;
    assign drive_access_done = done_q;
    // RULE18 remaining count
    assign xfer_remaining    = count;

    // Read decode.
    always_comb begin
        regs.rd_data = 8'h00;
        regs.rd_hit  = 1'b1;
        case (regs.rd_idx)
            ufdp_pkg::BUS_FAULT_FLAGS_IDX:     regs.rd_data = flags_q;
            ufdp_pkg::DRIVE_PIO_HIGH_BYTE_IDX: regs.rd_data = high_q;
            ufdp_pkg::DRIVE_PIO_LOW_BYTE_IDX:  regs.rd_data = low_q;
            ufdp_pkg::XFER_COUNT_BYTE0_IDX:    regs.rd_data = count[7:0];
            ufdp_pkg::XFER_COUNT_BYTE1_IDX:    regs.rd_data = count[15:8];
            ufdp_pkg::XFER_COUNT_BYTE2_IDX:    regs.rd_data = count[23:16];
            ufdp_pkg::XFER_COUNT_BYTE3_IDX:    regs.rd_data = count[31:24];
            ufdp_pkg::DRIVE_STATUS_IDX: begin
                regs.rd_data[ufdp_pkg::STAT_DONE_BIT]  = done_q;
                regs.rd_data[ufdp_pkg::STAT_FAULT_BIT] = |flags_q;
            end
            default:                           regs.rd_hit = 1'b0;
        endcase
    end
endmodule

// ### ufdp_regs_chk.sv
// Watches the register slice's pins for fault, access and count behaviour.
module ufdp_regs_chk (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        s_axi_wvalid,
    input  wire logic        ev_token_fault,
    input  wire logic        ev_stall_fault,
    input  wire logic        ev_data_toggle_fault,
    input  wire logic        ev_receive_fault,
    input  wire logic        ev_crc_fault,
    input  wire logic        fault_summary,
    input  wire logic        drive_access_start,
    input  wire logic        drive_access_end,
    input  wire logic        drive_access_read,
    input  wire logic        drive_access_wide,
    input  wire logic [15:0] drive_read_data,
    input  wire logic [7:0]  drive_write_high,
    input  wire logic        drive_access_done,
    input  wire logic        xfer_byte_done,
    input  wire logic [31:0] xfer_remaining
);
    timeunit 1ns;
    timeprecision 1ps;

    // One clock domain, and reset silences every check.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_token;
        ev_token_fault |=> fault_summary;
    endproperty
    a_token: assert property (p_token) else $error("token fault left summary low");
    property p_stall;
        $rose(ev_stall_fault) |=> fault_summary;
    endproperty
    a_stall: assert property (p_stall) else $error("stall fault left summary low");
    property p_toggle;
        ev_data_toggle_fault |-> ##1 fault_summary;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle fault missed");
    property p_rx;
        ev_receive_fault ##1 !ev_receive_fault |-> fault_summary;
    endproperty
    a_rx: assert property (p_rx) else $error("receive fault missed");
    property p_crc;
        ev_crc_fault |=> fault_summary [*2];
    endproperty
    a_crc: assert property (p_crc) else $error("checksum fault not held");
    property p_done_set;
        drive_access_end |=> drive_access_done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set");
    property p_done_clr;
        drive_access_start && !drive_access_end |=> !drive_access_done;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done not cleared");
    property p_high_cap;
        drive_access_end && drive_access_read && drive_access_wide && !s_axi_wvalid
            && !$past(s_axi_wvalid) |=> drive_write_high == 8'($past(drive_read_data) >> 8);
    endproperty
    a_high_cap: assert property (p_high_cap) else $error("upper byte not captured");
    property p_dec;
        xfer_byte_done && xfer_remaining != 32'h0 && !s_axi_wvalid && !$past(s_axi_wvalid)
            |=> xfer_remaining == $past(xfer_remaining) - 32'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("remaining count not decremented");
endmodule

bind ufdp_regs ufdp_regs_chk ufdp_regs_chk_inst (.*);

// ### ufdp_drive_model.sv
// Drive access sequencer stand-in: frames one programmed access per request.
module ufdp_drive_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic        go_read,
    input  wire logic        go_wide,
    input  wire logic [15:0] go_data,
    input  wire logic [3:0]  gap,
    output logic             drive_access_start,
    output logic             drive_access_end,
    output logic             drive_access_read,
    output logic             drive_access_wide,
    output logic [15:0]      drive_read_data,
    output logic             busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0]  left;
    logic [15:0] held;

    // Access outputs are quiet from time zero; busy stays unknown until reset clears it.
    initial begin
        {drive_access_start, drive_access_end, drive_access_read, drive_access_wide} = 4'h0;
        drive_read_data = 16'h0000;
    end

    // Start pulse, gap idle cycles, then the end pulse; data churns when unqualified.
    always @(posedge ref_clk) begin
        drive_access_start <= 1'b0;
        drive_access_end   <= 1'b0;
        drive_read_data    <= ~drive_read_data;
        if (rst) begin
            busy <= 1'b0;
            left <= 5'h00;
        end else if (go && !busy) begin
            drive_access_start <= 1'b1;
            drive_access_read  <= go_read;
            drive_access_wide  <= go_wide;
            held               <= go_data;
            left               <= {1'b0, gap} + 5'h01;
            busy               <= 1'b1;
        end else if (busy) begin
            left <= left - 5'h01;
            if (left == 5'h01) begin
                drive_access_end <= 1'b1;
                drive_read_data  <= held;
                busy             <= 1'b0;
            end
        end
    end
endmodule

// ### ufdp_regs_tb.sv
// Self-checking bench for the fault, drive holding and count registers.
module ufdp_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] FLT  = ufdp_pkg::BUS_FAULT_FLAGS_IDX;
    localparam logic [7:0] HI   = ufdp_pkg::DRIVE_PIO_HIGH_BYTE_IDX;
    localparam logic [7:0] LO   = ufdp_pkg::DRIVE_PIO_LOW_BYTE_IDX;
    localparam logic [7:0] CNT0 = ufdp_pkg::XFER_COUNT_BYTE0_IDX;
    localparam logic [7:0] STAT = ufdp_pkg::DRIVE_STATUS_IDX;
    logic        ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, ev_token_fault, ev_stall_fault, ev_data_toggle_fault;
    logic        ev_receive_fault, ev_crc_fault, fault_summary, drive_access_start;
    logic        drive_access_end, drive_access_read, drive_access_wide, drive_access_done;
    logic        xfer_byte_done, xfer_start, go, go_read, go_wide, busy;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, xfer_remaining, cnt, exp32;
    logic [3:0]  s_axi_wstrb, gap;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] drive_read_data, go_data;
    logic [7:0]  drive_write_high, e8, hi_q, lo_q;
    logic [4:0]  ev, e;
    logic [31:0] cnt_tab [3] = '{32'h0000_0001, 32'h0000_0100, 32'hFFFF_FFFF};
    int          mismatches = 0;
    int          compares = 0;
    int          starts = 0;
    int          seed, i, b, n;

    assign {ev_token_fault, ev_stall_fault, ev_data_toggle_fault, ev_receive_fault,
            ev_crc_fault} = ev;
    ufdp_regs ufdp_regs_inst (.*);
    ufdp_drive_model ufdp_drive_model_inst (.*);

    // Clock and a count of transfer start pulses.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (xfer_start) starts <= starts + 1;

    // Expected flag byte for a set of events.
    function automatic logic [7:0] fmask(input logic [4:0] f);
        return {1'b0, f[4], 1'b0, f[3], f[2], f[1], 1'b0, f[0]};
    endfunction

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus write: address and data offered together, each dropped once taken.
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d,
                          input logic [1:0] er = ufdp_pkg::RESP_OKAY);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk_resp(s_axi_bresp, er);
    endtask

    // Bus read with the response compared, and the byte too when OKAY is expected.
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                          input logic [1:0] er = ufdp_pkg::RESP_OKAY);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk_resp(s_axi_rresp, er);
        if (er == ufdp_pkg::RESP_OKAY) chk_data(s_axi_rdata, {24'h000000, exp});
    endtask

    task automatic stop_test;
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence: reset values, faults, drive accesses, transfer counts.
    initial begin
        seed = 32'h854f;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {ev, go, go_read, go_wide, xfer_byte_done} = 9'h000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, go_data, gap, lo_q} = 80'h0;
        s_axi_wstrb = 4'hE;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(FLT, 8'h00);
        axi_wr(HI, 8'hFF);
        s_axi_wstrb <= 4'hF;
        rd_chk(HI, 8'h00);
        rd_chk(LO, 8'h00);
        rd_chk(STAT, 8'h00);
        for (b = 0; b < 4; b++) rd_chk(CNT0 + 8'(b), 8'h00);
        rd_chk(8'hD0, 8'h00, ufdp_pkg::RESP_SLVERR);
        axi_wr(8'hD0, 8'hFF, ufdp_pkg::RESP_SLVERR);
        for (i = 0; i < 12; i++) begin
            e = (i < 5) ? 5'(1 << i) : 5'($random(seed));
            ev <= e;
            @(posedge ref_clk);
            ev <= 5'h00;
            @(posedge ref_clk);
            e8 = fmask(e);
            rd_chk(FLT, e8);
            rd_chk(STAT, {6'h00, |e8, 1'b0});
            chk_data(32'(fault_summary), 32'(|e8));
            axi_wr(FLT, ~e8);
            rd_chk(FLT, e8);
            axi_wr(FLT, e8);
            rd_chk(FLT, 8'h00);
            chk_data(32'(fault_summary), 32'h0);
        end
        for (i = 0; i < 8; i++) begin
            e8 = 8'($random(seed));
            axi_wr(HI, e8);
            chk_data(32'(drive_write_high), 32'(e8));
            hi_q = e8;
            go_data <= 16'($random(seed));
            go_read <= i[0];
            go_wide <= i[1];
            gap <= 4'(i * 2);
            go <= 1'b1;
            @(posedge ref_clk);
            go <= 1'b0;
            do @(posedge ref_clk); while (busy);
            @(posedge ref_clk);
            if (go_read) lo_q = go_data[7:0];
            if (go_read && go_wide) hi_q = go_data[15:8];
            rd_chk(STAT, 8'h01);
            rd_chk(LO, lo_q);
            rd_chk(HI, hi_q);
            if (i[2]) begin
                axi_wr(STAT, 8'h01);
                rd_chk(STAT, 8'h00);
            end
        end
        for (i = 0; i < 4; i++) begin
            cnt = (i == 3) ? 32'($random(seed)) : cnt_tab[i];
            n = starts;
            for (b = 3; b >= 0; b--) axi_wr(CNT0 + 8'(b), cnt[8*b +: 8]);
            repeat (2) @(posedge ref_clk);
            chk_data(32'(starts - n), 32'h1);
            chk_data(xfer_remaining, cnt);
            xfer_byte_done <= 1'b1;
            repeat (i + 2) @(posedge ref_clk);
            xfer_byte_done <= 1'b0;
            @(posedge ref_clk);
            exp32 = (cnt > 32'(i + 2)) ? cnt - 32'(i + 2) : 32'h0;
            for (b = 0; b < 4; b++) rd_chk(CNT0 + 8'(b), exp32[8*b +: 8]);
        end
        stop_test();
    end

    // Watchdog: the sequence needs under a thousand cycles; this allows fifty thousand.
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end
endmodule
